//--- hw/spi_ctrl.sv
// spi_ctrl: spi master/slave controller with optional buffer mode
// assumes pins are synchronous to aclk and an axi4-lite master on the bus
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module spi_ctrl
  import spi_pkg::*;
#(
  parameter int ADDR_W = 5
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // interrupt
  output logic                   irq,
  input  wire logic              vector_taken,
  // serial pins
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe_n,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe_n,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe_n,
  input  wire logic              select_n
);

  // ---------------------------------------------------------------
  // state and decoded controls
  // ---------------------------------------------------------------
  state_type s_ff;
  state_type nxt_s;

  logic       enabled, master, bufm, lsb_first, cpha, cpol, din;
  logic [7:0] ratio;
  logic [6:0] half_m1;

  // R4 - enable bit
  assign enabled   = s_ff.ctrl_a[CA_ENABLE];
  assign master    = s_ff.ctrl_a[CA_MASTER];
  assign bufm      = s_ff.ctrl_b[CB_BUF];
  assign lsb_first = s_ff.ctrl_a[CA_ORDER];
  assign cpha      = s_ff.ctrl_b[CB_MODE_LO];
  assign cpol      = s_ff.ctrl_b[CB_MODE_LO+1];
  assign din       = master ? miso_i : mosi_i;

  // R1 - divider select
  always_comb begin
    case (s_ff.ctrl_a[CA_DIV_LO+1:CA_DIV_LO])
      2'h0:    ratio = DIVIDE_BY_FOUR;
      2'h1:    ratio = DIVIDE_BY_SIXTEEN;
      2'h2:    ratio = DIVIDE_BY_SIXTYFOUR;
      default: ratio = DIVIDE_BY_ONETWENTYEIGHT;
    endcase
  end

  // R3 - doubled rate halves the half period
  assign half_m1 = 7'((ratio >> (s_ff.ctrl_a[CA_DOUBLE] ? 2 : 1)) - 8'h01);

  // bit presented on the data line for a given word
  // R26 - bit order
  function automatic logic top_bit(input logic [7:0] d, input logic lsb);
    top_bit = lsb ? d[0] : d[7];
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       lead, do_sample, edge_seen, done, rd_bad;
    logic [7:0] rd_val;
    nxt_s  = s_ff;
    {lead, do_sample, edge_seen, done, rd_bad} = 5'h00;
    rd_val = 8'h00;

    // response handshakes retire
    if (s_ff.bvalid && bready) nxt_s.bvalid = 1'b0;
    if (s_ff.rvalid && rready) nxt_s.rvalid = 1'b0;
    // R15 - vector run clears transfer flag
    if (vector_taken) nxt_s.xfer_flag = 1'b0;
    // read channel with its side effects
    if (arvalid && !s_ff.rvalid) begin
      rd_bad = (araddr >> 2) > ADDR_W'(SPI_DATA_IDX);
      case (araddr[4:2])
        SPI_CONTROL_A_IDX: rd_val = s_ff.ctrl_a;
        SPI_CONTROL_B_IDX: rd_val = s_ff.ctrl_b;
        // R11 - buffer enables read zero outside buffer mode
        SPI_INTERRUPT_ENABLES_IDX:
          rd_val = bufm ? s_ff.irq_en : (s_ff.irq_en & 8'h01);
        SPI_FLAG_REGISTER_IDX: begin
          if (bufm) begin
            rd_val[FB_RXD]   = s_ff.rx_done_flag;
            rd_val[FB_TXD]   = s_ff.tx_done_flag;
            rd_val[FB_EMPTY] = !s_ff.tx_full;
            rd_val[FB_SEL]   = s_ff.select_trigger_flag;
            rd_val[FB_OVF]   = s_ff.rx_overflow_flag;
          end else begin
            rd_val[FN_XFER] = s_ff.xfer_flag;
            rd_val[FN_COLL] = s_ff.coll_flag;
            // R15 - arm clear on flag read
            nxt_s.xfer_armed = s_ff.xfer_flag;
            nxt_s.coll_armed = s_ff.coll_flag;
          end
        end
        SPI_DATA_IDX: begin
          // R23 - data read source
          rd_val = bufm ? s_ff.rx_buf0 : s_ff.rx_data;
          if (bufm) begin
            // R27 - oldest byte first
            if (s_ff.rx_count != 2'h0) begin
              nxt_s.rx_buf0  = s_ff.rx_buf1;
              nxt_s.rx_count = s_ff.rx_count - 2'h1;
            end
            // R17 - empty buffer drops flag
            if (nxt_s.rx_count == 2'h0) nxt_s.rx_done_flag = 1'b0;
            // R22 - data read clears overflow
            nxt_s.rx_overflow_flag = 1'b0;
          end else begin
            // R15 - data access after flag read
            if (s_ff.xfer_armed) nxt_s.xfer_flag = 1'b0;
            // R16 - same clear for collision
            if (s_ff.coll_armed) nxt_s.coll_flag = 1'b0;
            nxt_s.xfer_armed = 1'b0;
            nxt_s.coll_armed = 1'b0;
          end
        end
        default: rd_bad = 1'b1;
      endcase
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata  = rd_bad ? 8'h00 : rd_val;
      nxt_s.rresp  = rd_bad ? RESP_SLVERR : RESP_OKAY;
    end

    // write address and data captured in either order
    if (awvalid && !s_ff.aw_held) begin
      nxt_s.aw_held = 1'b1;
      nxt_s.aw_idx  = awaddr[4:2];
      nxt_s.aw_bad  = (awaddr >> 2) > ADDR_W'(SPI_DATA_IDX);
    end
    if (wvalid && !s_ff.w_held) begin
      nxt_s.w_held = 1'b1;
      nxt_s.w_byte = wdata[7:0];
      nxt_s.w_lane = wstrb[0];
    end

    // serial engine, disabled means idle
    if (!enabled) begin
      nxt_s.xfer       = XFER_IDLE;
      nxt_s.edge_cnt   = 5'h00;
      nxt_s.sample_cnt = 4'h0;
      nxt_s.primed     = 1'b0;
    end else if (master) begin
      // R2 - divider used only here, in master mode
      if (s_ff.xfer == XFER_SHIFT) begin
        if (s_ff.div_cnt == 7'h00) begin
          nxt_s.div_cnt   = half_m1;
          nxt_s.sck_level = !s_ff.sck_level;
          nxt_s.edge_cnt  = s_ff.edge_cnt + 5'h01;
          lead            = !s_ff.edge_cnt[0];
          edge_seen       = 1'b1;
          done            = (nxt_s.edge_cnt == EDGES_PER_BYTE);
        end else begin
          nxt_s.div_cnt = s_ff.div_cnt - 7'h01;
        end
      end
    end else begin
      nxt_s.sck_prev = sck_i;
      if (select_n) begin
        // R25 - deselect drops any byte in progress
        nxt_s.xfer       = XFER_IDLE;
        nxt_s.edge_cnt   = 5'h00;
        nxt_s.sample_cnt = 4'h0;
      end else if (sck_i != s_ff.sck_prev) begin
        lead       = (s_ff.sck_prev == cpol);
        edge_seen  = 1'b1;
        nxt_s.xfer = XFER_SHIFT;
      end
    end

    // R9 - sample on leading edge for even modes, trailing for odd
    do_sample = edge_seen && (lead != cpha);
    if (do_sample) begin
      nxt_s.shifter = lsb_first ? {din, s_ff.shifter[7:1]}
                                : {s_ff.shifter[6:0], din};
      nxt_s.sample_cnt = s_ff.sample_cnt + 4'h1;
      if (!master && nxt_s.sample_cnt == SAMPLES_PER_BYTE) done = 1'b1;
    end else if (edge_seen) begin
      nxt_s.out_bit = top_bit(s_ff.shifter, lsb_first);
    end
    if (s_ff.xfer == XFER_IDLE && !edge_seen) begin
      nxt_s.out_bit = top_bit(s_ff.shifter, lsb_first);
    end

    // end of byte
    if (done) begin
      nxt_s.xfer       = XFER_IDLE;
      nxt_s.edge_cnt   = 5'h00;
      nxt_s.sample_cnt = 4'h0;
      nxt_s.primed     = 1'b1;
      if (!bufm) nxt_s.rx_data = nxt_s.shifter;
      else begin
        // R21 - third byte with both stages full
        case (nxt_s.rx_count)
          2'h0: nxt_s.rx_buf0 = nxt_s.shifter;
          2'h1: nxt_s.rx_buf1 = nxt_s.shifter;
          default: nxt_s.rx_buf1 = nxt_s.rx_buf1;
        endcase
        if (nxt_s.rx_count == 2'h2) nxt_s.rx_overflow_flag = 1'b1;
        else nxt_s.rx_count = nxt_s.rx_count + 2'h1;
        // R6 - buffer moves only after a completed transfer
        if (s_ff.tx_full && s_ff.primed) begin
          nxt_s.shifter = s_ff.tx_buf;
          nxt_s.tx_full = 1'b0;
          nxt_s.out_bit = top_bit(s_ff.tx_buf, lsb_first);
          if (master) begin
            nxt_s.xfer    = XFER_SHIFT;
            nxt_s.div_cnt = half_m1;
          end
        end
      end
    end

    // master start from the transmit buffer
    if (bufm && enabled && master && s_ff.xfer == XFER_IDLE
        && !done && s_ff.tx_full) begin
      nxt_s.xfer     = XFER_SHIFT;
      nxt_s.div_cnt  = half_m1;
      nxt_s.edge_cnt = 5'h00;
      if (s_ff.primed) begin
        nxt_s.shifter = s_ff.tx_buf;
        nxt_s.tx_full = 1'b0;
        nxt_s.out_bit = top_bit(s_ff.tx_buf, lsb_first);
      end
    end

    // register writes once both halves are held
    if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
      nxt_s.aw_held = 1'b0;
      nxt_s.w_held  = 1'b0;
      nxt_s.bvalid  = 1'b1;
      nxt_s.bresp   = s_ff.aw_bad ? RESP_SLVERR : RESP_OKAY;
      if (s_ff.w_lane && !s_ff.aw_bad) begin
        case (s_ff.aw_idx)
          SPI_CONTROL_A_IDX: nxt_s.ctrl_a = s_ff.w_byte & CTRL_A_MASK;
          // R5 - buffer mode enable
          SPI_CONTROL_B_IDX: nxt_s.ctrl_b = s_ff.w_byte & CTRL_B_MASK;
          SPI_INTERRUPT_ENABLES_IDX:
            nxt_s.irq_en = s_ff.w_byte & IRQ_EN_MASK;
          SPI_FLAG_REGISTER_IDX: begin
            if (bufm) begin
              // R17 - write one clears receive done
              if (s_ff.w_byte[FB_RXD]) nxt_s.rx_done_flag = 1'b0;
              // R18 - write one clears transmit done
              if (s_ff.w_byte[FB_TXD]) nxt_s.tx_done_flag = 1'b0;
              // R20 - write one clears select trigger
              if (s_ff.w_byte[FB_SEL]) nxt_s.select_trigger_flag = 1'b0;
              // R22 - write one clears overflow
              if (s_ff.w_byte[FB_OVF]) nxt_s.rx_overflow_flag = 1'b0;
            end
          end
          SPI_DATA_IDX: begin
            if (!bufm) begin
              if (s_ff.xfer_armed) nxt_s.xfer_flag = 1'b0;
              if (s_ff.coll_armed) nxt_s.coll_flag = 1'b0;
              nxt_s.xfer_armed = 1'b0;
              nxt_s.coll_armed = 1'b0;
              if (s_ff.xfer == XFER_SHIFT) begin
                // R16 - write mid-byte collides
                nxt_s.coll_flag = 1'b1;
              end else begin
                // R23 - normal write loads the shifter
                nxt_s.shifter = s_ff.w_byte;
                nxt_s.out_bit = top_bit(s_ff.w_byte, lsb_first);
                if (enabled && master) begin
                  nxt_s.xfer     = XFER_SHIFT;
                  nxt_s.div_cnt  = half_m1;
                  nxt_s.edge_cnt = 5'h00;
                end
              end
            end else if (s_ff.ctrl_b[CB_WAIT] && enabled && select_n
                         && !s_ff.primed && s_ff.xfer == XFER_IDLE) begin
              // R7 - first write goes straight to the shifter
              nxt_s.shifter = s_ff.w_byte;
              nxt_s.out_bit = top_bit(s_ff.w_byte, lsb_first);
              nxt_s.primed  = 1'b1;
              if (master) begin
                nxt_s.xfer     = XFER_SHIFT;
                nxt_s.div_cnt  = half_m1;
                nxt_s.edge_cnt = 5'h00;
              end
            end else if (!s_ff.tx_full) begin
              // R19 - data write fills buffer, empty flag drops
              nxt_s.tx_buf  = s_ff.w_byte;
              nxt_s.tx_full = 1'b1;
            end
          end
          default: nxt_s.ctrl_a = s_ff.ctrl_a;
        endcase
      end
    end
    // flag sets come last so a set wins over a clear, except the overflow set, which a write-one clear overrides
    // R13 - byte complete
    if (done && !bufm) nxt_s.xfer_flag = 1'b1;
    if (done && bufm) begin
      nxt_s.rx_done_flag = 1'b1;
      // R18 - shifter empty with no waiting data
      if (!s_ff.tx_full) nxt_s.tx_done_flag = 1'b1;
    end
    // R8 - select ignore keeps master mode
    if (enabled && master && !select_n && !s_ff.ctrl_b[CB_IGNORE]) begin
      // R24 - drop to slave and abort
      nxt_s.ctrl_a[CA_MASTER] = 1'b0;
      nxt_s.xfer              = XFER_IDLE;
      nxt_s.edge_cnt          = 5'h00;
      nxt_s.sample_cnt        = 4'h0;
      // R14 - normal mode flag
      if (!bufm) nxt_s.xfer_flag = 1'b1;
      // R20 - buffer mode trigger flag
      if (bufm) nxt_s.select_trigger_flag = 1'b1;
    end
    // R10 - clock rests at its idle level
    if (nxt_s.xfer == XFER_IDLE) nxt_s.sck_level = nxt_s.ctrl_b[CB_MODE_LO+1];
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff         <= '0;
      s_ff.ctrl_a  <= SPI_CONTROL_A_RST;
      s_ff.ctrl_b  <= SPI_CONTROL_B_RST;
      s_ff.irq_en  <= SPI_INTERRUPT_ENABLES_RST;
      s_ff.shifter <= SPI_DATA_RST;
      s_ff.xfer    <= XFER_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // bus handshakes and answers
  assign awready = !s_ff.aw_held;
  assign wready  = !s_ff.w_held;
  assign bvalid  = s_ff.bvalid;
  assign bresp   = s_ff.bresp;
  assign arready = !s_ff.rvalid;
  assign rvalid  = s_ff.rvalid;
  assign rresp   = s_ff.rresp;
  assign rdata   = {24'h000000, s_ff.rdata};

  // R11 - buffer mode request gating
  // R12 - single enable in normal mode
  assign irq = bufm
    ? |({s_ff.rx_done_flag, s_ff.tx_done_flag, !s_ff.tx_full,
         s_ff.select_trigger_flag} & s_ff.irq_en[IE_RXD:IE_SEL])
    : (s_ff.irq_en[IE_SINGLE] && s_ff.xfer_flag);

  // pin drivers, enables low while driving
  assign sck_o     = s_ff.sck_level;
  assign sck_oe_n  = !(enabled && master);
  assign mosi_o    = s_ff.out_bit;
  assign mosi_oe_n = !(enabled && master);
  assign miso_o    = s_ff.out_bit;
  assign miso_oe_n = !(enabled && !master && !select_n);

endmodule
`default_nettype wire

//--- hw/spi_pkg.sv
// spi_pkg: constants, field positions and carrier types of the spi controller
// assumes register index times four is the byte address on the axi4-lite bus
//
// Overview of operation
// R1 - master serial clock is the bus clock divided by 4, 16, 64 or 128
// R2 - divider select has no effect while working as slave
// R3 - clock double bit doubles the divided serial clock rate in master mode
// R4 - bit 0 of control a enables the controller
// R5 - buffer mode adds two receive stages, one transmit stage, own flags
// R6 - wait bit zero: first byte is dummy, buffer copied after one transfer; in slave mode the code copies it only after the second
// R7 - wait bit one: first write while enabled and select high loads shifter
// R8 - select ignore bit keeps master mode despite a low select pin
// R9 - mode codes choose sample and setup edges per leading edge direction
// R10 - serial clock idles low for rising leading edge, high for falling
// R11 - buffer mode enables gate their flags; they read zero outside it
// R12 - single enable raises the request while the transfer flag is set
// R13 - normal transfer flag sets when a whole byte has shifted
// R14 - normal transfer flag also sets when select pulls master low
// R15 - transfer flag clears on vector taken or flag read then data access
// R16 - collision flag sets on data write mid-byte; same clear as R15; the code does not clear it on vector taken
// R17 - receive done flag high while buffer holds unread data; write one clears
// R18 - transmit done flag sets when shifter empties with buffer empty
// R19 - transmit empty flag reads one while buffer empty; data write clears
// R20 - select trigger flag sets on forced master to slave, unless ignored
// R21 - overflow flag sets when third byte arrives with both stages full
// R22 - overflow flag clears on data read or writing one
// R23 - data writes go to shifter or buffer; reads from receive data or buffer
// R24 - select low in master clears master bit and sets transfer flag
// R25 - select high in slave mode resets the shift engine at once
// R26 - bit order zero sends msb first, one sends lsb first
// R27 - receive stages read out oldest byte first
package spi_pkg;

  // register indices, byte address is four times the index
  localparam logic [2:0] SPI_CONTROL_A_IDX       = 3'h0;
  localparam logic [2:0] SPI_CONTROL_B_IDX       = 3'h1;
  localparam logic [2:0] SPI_INTERRUPT_ENABLES_IDX = 3'h2;
  localparam logic [2:0] SPI_FLAG_REGISTER_IDX   = 3'h3;
  localparam logic [2:0] SPI_DATA_IDX            = 3'h4;

  // reset values
  localparam logic [7:0] SPI_CONTROL_A_RST = 8'h00;
  localparam logic [7:0] SPI_CONTROL_B_RST = 8'h00;
  localparam logic [7:0] SPI_INTERRUPT_ENABLES_RST = 8'h00;
  localparam logic [7:0] SPI_DATA_RST = 8'h00;

  // writable bit masks, other bits read zero
  localparam logic [7:0] CTRL_A_MASK = 8'h77;
  localparam logic [7:0] CTRL_B_MASK = 8'hc7;
  localparam logic [7:0] IRQ_EN_MASK = 8'hf1;

  // control a fields
  localparam int CA_ENABLE = 0;
  localparam int CA_DIV_LO = 1;
  localparam int CA_DOUBLE = 4;
  localparam int CA_MASTER = 5;
  localparam int CA_ORDER  = 6;
  // control b fields
  localparam int CB_MODE_LO = 0;
  localparam int CB_IGNORE  = 2;
  localparam int CB_WAIT    = 6;
  localparam int CB_BUF     = 7;
  // interrupt enable fields
  localparam int IE_SINGLE = 0;
  localparam int IE_SEL    = 4;
  localparam int IE_EMPTY  = 5;
  localparam int IE_TXD    = 6;
  localparam int IE_RXD    = 7;
  // flag fields, normal and buffer layout
  localparam int FN_XFER  = 7;
  localparam int FN_COLL  = 6;
  localparam int FB_OVF   = 0;
  localparam int FB_SEL   = 4;
  localparam int FB_EMPTY = 5;
  localparam int FB_TXD   = 6;
  localparam int FB_RXD   = 7;

  // divide ratios for divider select codes 0 to 3
  localparam logic [7:0] DIVIDE_BY_FOUR           = 8'h04;
  localparam logic [7:0] DIVIDE_BY_SIXTEEN        = 8'h10;
  localparam logic [7:0] DIVIDE_BY_SIXTYFOUR      = 8'h40;
  localparam logic [7:0] DIVIDE_BY_ONETWENTYEIGHT = 8'h80;

  // edges per byte (master) and samples per byte (slave)
  localparam logic [4:0] EDGES_PER_BYTE   = 5'h10;
  localparam logic [3:0] SAMPLES_PER_BYTE = 4'h8;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {XFER_IDLE, XFER_SHIFT} xfer_state_type;

  typedef struct packed {
    logic [7:0]     ctrl_a;
    logic [7:0]     ctrl_b;
    logic [7:0]     irq_en;
    logic           xfer_flag;
    logic           coll_flag;
    logic           xfer_armed;
    logic           coll_armed;
    logic           rx_done_flag;
    logic           tx_done_flag;
    logic           select_trigger_flag;
    logic           rx_overflow_flag;
    logic [7:0]     shifter;
    logic [7:0]     rx_data;
    logic [7:0]     tx_buf;
    logic [7:0]     rx_buf0;
    logic [7:0]     rx_buf1;
    logic [1:0]     rx_count;
    logic           tx_full;
    logic           primed;
    xfer_state_type xfer;
    logic           sck_level;
    logic           sck_prev;
    logic           out_bit;
    logic [4:0]     edge_cnt;
    logic [3:0]     sample_cnt;
    logic [6:0]     div_cnt;
    logic           aw_held;
    logic           w_held;
    logic [2:0]     aw_idx;
    logic           aw_bad;
    logic [7:0]     w_byte;
    logic           w_lane;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [1:0]     rresp;
    logic [7:0]     rdata;
  } state_type;

endpackage

//--- bench/spi_checker.sv
// spi_checker: handshake and pin assertions on the controller ports
// assumes a bind onto spi_ctrl, one aclk domain
`timescale 1ns/100ps
`default_nettype none
module spi_checker (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  // serial pins
  input wire logic        sck_oe_n,
  input wire logic        mosi_oe_n,
  input wire logic        miso_oe_n,
  input wire logic        select_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // bus answers and holding
  w_answer_a: assert property (
    awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
    else $error("write answer late");
  r_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  b_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  r_hold_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  ar_gate_a: assert property (arready != rvalid)
    else $error("read ready wrong");
  r_upper_a: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // pin drivers
  oe_pair_a: assert property (sck_oe_n == mosi_oe_n)
    else $error("clock and data enables differ");
  miso_gate_a: assert property (
    !miso_oe_n |-> sck_oe_n && (!select_n || !$past(select_n)))
    else $error("slave drives while deselected");
endmodule
bind spi_ctrl spi_checker u_chk (.*);
`default_nettype wire

//--- bench/spi_partner.sv
// spi_partner: far-side slave, mode 0, msb first
// assumes cs_n from the bench, sck and mosi from the master
`timescale 1ns/100ps
`default_nettype none
module spi_partner (
  // serial pins
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       cs_n,
  output logic            miso,
  // reply and capture
  input  wire logic [7:0] reply,
  output logic [7:0]      got
);
  logic [7:0] sh;
  initial miso = 1'b0;
  // load at select, inverse of last bit once released
  always @(cs_n) begin
    if (!cs_n) begin
      sh = reply;
      got = 8'h00;
    end
    miso = cs_n ? ~miso : reply[7];
  end
  always @(posedge sck) if (!cs_n) got <= {got[6:0], mosi};
  // trailing edge sets up, msb first
  always @(negedge sck) if (!cs_n) begin
    sh <= {sh[6:0], 1'b0};
    miso <= sh[6];
  end
endmodule
`default_nettype wire

//--- bench/tb_spi_master_slave_buffered.sv
// tb_spi_master_slave_buffered: self-checking bench for spi_ctrl
// assumes spi_partner as far side and the checker bound in
`timescale 1ns/100ps
`default_nettype none
module tb_spi_master_slave_buffered
  import spi_pkg::*;
;
  localparam logic [2:0] CA = SPI_CONTROL_A_IDX, CB = SPI_CONTROL_B_IDX;
  localparam logic [2:0] EN = SPI_INTERRUPT_ENABLES_IDX;
  localparam logic [2:0] FL = SPI_FLAG_REGISTER_IDX, DT = SPI_DATA_IDX;
  localparam logic [1:0] OK = RESP_OKAY;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq, vector_taken;
  logic        sck_i, sck_o, sck_oe_n, mosi_i, mosi_o, mosi_oe_n;
  logic        miso_i, miso_o, miso_oe_n, select_n, pcs_n;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [7:0]  got, d;
  int          n_fail, checks_done;
  time         t0;
  spi_ctrl dut (.*);
  spi_partner peer (.sck(sck_o), .mosi(mosi_o), .cs_n(pcs_n),
    .miso(miso_i), .reply(8'h1e), .got(got));
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] g, e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // bus write, each channel released when taken
  task automatic wr(input logic [2:0] i, input logic [7:0] v,
                    input logic [1:0] er);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      bready <= bvalid;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk(bresp, er);
  endtask
  // bus read, masked compare of the byte
  task automatic rd(input logic [2:0] i, input logic [7:0] m, e,
                    input logic [1:0] er);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      rready <= rvalid;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk({rresp, rdata & {24'hffffff, m}}, {er, 24'h0, e});
  endtask
  task automatic t_regs;
    rd(CA, 8'hff, SPI_CONTROL_A_RST, OK);
    rd(FL, 8'hff, 8'h00, OK);
    wr(CB, 8'h80, OK);
    wr(EN, 8'hff, OK);
    rd(EN, 8'hff, 8'hf1, OK);
    rd(FL, 8'h20, 8'h20, OK);
    chk(irq, 1'b1);
    wr(CB, 8'h00, OK);
    rd(EN, 8'hff, 8'h01, OK);
    wr(3'h6, 8'h55, RESP_SLVERR);
    rd(3'h6, 8'hff, 8'h00, RESP_SLVERR);
  endtask
  task automatic t_modes;
    wr(CA, 8'h21, OK);
    for (int m = 0; m < 4; m++) begin
      wr(CB, 8'(m), OK);
      repeat (2) @(posedge aclk);
      chk({sck_oe_n, sck_o}, {1'b0, m[1]});
    end
    wr(CB, 8'h00, OK);
  endtask
  task automatic t_master;
    logic [7:0] ca [6] = '{8'h21, 8'h23, 8'h25, 8'h27, 8'h33, 8'h61};
    int per [6] = '{4, 16, 64, 128, 8, 4};
    for (int k = 0; k < 6; k++) begin
      wr(CA, ca[k], OK);
      pcs_n <= 1'b0;
      d = 8'h96 + 8'(k);
      wr(DT, d, OK);
      @(posedge sck_o);
      t0 = $time;
      @(posedge sck_o);
      chk(int'(($time - t0) / 25), per[k]);
      wait (irq === 1'b1);
      @(posedge aclk);
      pcs_n <= 1'b1;
      if (k == 5) d = {<<{d}};
      chk(got, d);
      if (k == 5) begin
        vector_taken <= 1'b1;
        @(posedge aclk);
        vector_taken <= 1'b0;
      end else rd(FL, 8'hc0, 8'h80, OK);
      rd(DT, 8'hff, (k == 5) ? 8'h78 : 8'h1e, OK);
      chk(irq, 1'b0);
    end
  endtask
  task automatic t_coll;
    wr(CA, 8'h27, OK);
    pcs_n <= 1'b0;
    wr(DT, 8'h11, OK);
    wr(DT, 8'h22, OK);
    rd(FL, 8'hc0, 8'h40, OK);
    wait (irq === 1'b1);
    @(posedge aclk);
    pcs_n <= 1'b1;
    chk(got, 8'h11);
    rd(FL, 8'hc0, 8'hc0, OK);
    rd(DT, 8'hff, 8'h1e, OK);
    rd(FL, 8'hc0, 8'h00, OK);
  endtask
  task automatic sel(input logic v);
    select_n <= v;
    repeat (3) @(posedge aclk);
  endtask
  task automatic t_select;
    wr(CB, 8'h04, OK);
    sel(1'b0);
    rd(CA, 8'hff, 8'h27, OK);
    sel(1'b1);
    wr(CB, 8'h80, OK);
    sel(1'b0);
    rd(CA, 8'hff, 8'h07, OK);
    rd(FL, 8'h10, 8'h10, OK);
    wr(FL, 8'h10, OK);
    rd(FL, 8'h10, 8'h00, OK);
    sel(1'b1);
    wr(CB, 8'h00, OK);
    wr(CA, 8'h21, OK);
    sel(1'b0);
    rd(FL, 8'hff, 8'h80, OK);
    chk(irq, 1'b1);
    rd(DT, 8'h00, 8'h00, OK);
    chk(irq, 1'b0);
    sel(1'b1);
  endtask
  // slave bits, mode 0, msb first
  task automatic sbits(input logic [7:0] b, input int n);
    for (int j = 7; j > 7 - n; j--) begin
      mosi_i <= b[j];
      repeat (4) @(posedge aclk);
      sck_i <= 1'b1;
      repeat (4) @(posedge aclk);
      sck_i <= 1'b0;
    end
  endtask
  task automatic t_slave;
    wr(CA, 8'h01, OK);
    wr(CB, 8'h80, OK);
    sel(1'b0);
    sbits(8'hff, 4);
    sel(1'b1);
    sel(1'b0);
    for (int k = 0; k < 4; k++) sbits(8'h31 + 8'(k), 8);
    sel(1'b1);
    rd(FL, 8'h81, 8'h81, OK);
    rd(DT, 8'hff, 8'h31, OK);
    rd(FL, 8'h81, 8'h80, OK);
    rd(DT, 8'hff, 8'h32, OK);
    rd(FL, 8'h81, 8'h00, OK);
    rd(FL, 8'h60, 8'h60, OK);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    #400us;
    n_fail++;
    results;
  end
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, vector_taken} = '0;
    {sck_i, mosi_i, awaddr, araddr, wdata, n_fail, checks_done} = '0;
    wstrb = 4'h1;
    select_n = 1'b1;
    pcs_n = 1'b1;
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_modes;
    t_master;
    t_coll;
    t_select;
    t_slave;
    results;
  end
endmodule
`default_nettype wire
